// File: rtl/paof_top.sv
`timescale 1ns/1ps
module paof_top
  import paof_pkg::*;
(
  input  wire logic               CLOCK,          // i/o clock
  input  wire logic               RST,            // sync reset, high
  input  wire logic [7:0]         DIR_BITS,       // data direction bits
  input  wire logic [7:0]         PORT_BITS,      // port output bits
  input  paof_pkg::paof_periph_s  PERIPH,         // peripheral controls
  input  wire logic [7:0]         PAD_IN,         // pad levels
  output logic      [7:0]         PAD_OE,         // driver enable per pad
  output logic      [7:0]         PAD_OUT,        // driven value per pad
  output logic      [7:0]         PAD_PULLUP,     // pull-up enable per pad
  output logic      [7:0]         PIN_CHANGE_SRC, // pin change sources
  output logic                    SPI_SLAVE_ACTIVE, // slave selected
  output logic                    REFERENCE_VOLTAGE_OUTPUT, // ref driven on bit7
  output logic      [7:0]         PAD_IN_Q        // registered pad levels
);

  import paof_pkg::*;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  logic spi_m;
  logic spi_s;
  logic lin_tx_en;
  logic ref_off;
  paof_ovr_s ovr [PIN_COUNT];
  logic [7:0] pad_oe_raw;
  logic [7:0] pad_out_raw;
  logic [7:0] pad_pull_raw;
  logic [7:0] pad_in_q;

  // no flops here: pads follow the enables in the same cycle
  always_comb begin
    spi_m     = PERIPH.spi_enable & PERIPH.spi_master;
    spi_s     = PERIPH.spi_enable & ~PERIPH.spi_master;
    lin_tx_en = PERIPH.uart_tx_enable | PERIPH.lin_enable;
    ref_off   = (PERIPH.ref_out_enable & PERIPH.adc_internal_ref)
              | PERIPH.adc_external_ref;
    REFERENCE_VOLTAGE_OUTPUT = PERIPH.ref_out_enable & PERIPH.adc_internal_ref;
  end

  // ****************************************************************
  // per-pin override tables
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      ovr[i] = '0;
    end
    // select pad: forced input as slave, pull-up by port bit
    ovr[PIN_SEL].ddoe = spi_s;
    ovr[PIN_SEL].puoe = spi_s;
    ovr[PIN_SEL].puov = PORT_BITS[PIN_SEL] & ~PERIPH.pullup_disable;
    // clock pad
    ovr[PIN_SCK].ddoe = spi_s;
    ovr[PIN_SCK].puoe = spi_s;
    ovr[PIN_SCK].puov = PORT_BITS[PIN_SCK] & ~PERIPH.pullup_disable;
    ovr[PIN_SCK].pvoe = spi_m;
    ovr[PIN_SCK].pvov = PERIPH.spi_sck_out;
    // master-out/slave-in pad; three-wire mode leaves it alone
    ovr[PIN_MOSI].ddoe = spi_s;
    ovr[PIN_MOSI].puoe = spi_s;
    ovr[PIN_MOSI].puov = PORT_BITS[PIN_MOSI] & ~PERIPH.pullup_disable;
    ovr[PIN_MOSI].pvoe = spi_m;
    ovr[PIN_MOSI].pvov = PERIPH.spi_mosi_out;
    // master-in/slave-out pad
    ovr[PIN_MISO].ddoe = spi_m;
    ovr[PIN_MISO].puoe = spi_m;
    ovr[PIN_MISO].puov = PORT_BITS[PIN_MISO] & ~PERIPH.pullup_disable;
    // value only; direction bit still gates the driver
    ovr[PIN_MISO].pvoe = spi_s | PERIPH.three_wire_mode | PERIPH.timer0_oc_en;
    ovr[PIN_MISO].pvov = spi_s ? PERIPH.spi_miso_out :
                         PERIPH.three_wire_mode ? PERIPH.three_wire_dout :
                         PERIPH.timer0_oc_val;
    // transmit pad
    ovr[PIN_TX].ddoe = lin_tx_en;
    ovr[PIN_TX].direction_override_value = lin_tx_en;
    ovr[PIN_TX].puoe = lin_tx_en;
    ovr[PIN_TX].puov = 1'b0;
    ovr[PIN_TX].pvoe = lin_tx_en;
    ovr[PIN_TX].pvov = PERIPH.lin_enable ? PERIPH.lin_tx_data : PERIPH.uart_tx_data;
    // reference pad
    ovr[PIN_REF].ddoe = ref_off;
    ovr[PIN_REF].direction_override_value = 1'b0;
    ovr[PIN_REF].puoe = ref_off;
    ovr[PIN_REF].puov = 1'b0;
  end

  // ****************************************************************
  // pin slices
  // ****************************************************************
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    paof_pin u_pin (
      .dir_bit  (DIR_BITS[g]),
      .port_bit (PORT_BITS[g]),
      .pud      (PERIPH.pullup_disable),
      .ovr      (ovr[g]),
      .oe       (pad_oe_raw[g]),
      .val      (pad_out_raw[g]),
      .pull     (pad_pull_raw[g])
    );
  end

  always_comb begin
    PAD_OE     = pad_oe_raw;
    PAD_OUT    = pad_out_raw & pad_oe_raw;
    PAD_PULLUP = pad_pull_raw;
  end

  // ****************************************************************
  // input side
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pad_in_q <= RST_BYTE;
    end else begin
      pad_in_q <= PAD_IN;
    end
  end

  always_comb begin
    PAD_IN_Q         = pad_in_q;
    PIN_CHANGE_SRC   = PAD_IN;
    // active-low select; master must hold it low for the whole frame
    SPI_SLAVE_ACTIVE = spi_s & ~PAD_IN[PIN_SEL];
  end

  // software's job: bit4 input for three-wire receive, bit2 output for timer

endmodule // paof_top

// File: common/paof_pkg.sv
package paof_pkg;

  // ****************************************************************
  // pin positions on port a
  // ****************************************************************
  localparam int PIN_COUNT     = 8;
  localparam int PIN_RX        = 0;
  localparam int PIN_TX        = 1;
  localparam int PIN_MISO      = 2;
  localparam int PIN_MOSI      = 4;
  localparam int PIN_SCK       = 5;
  localparam int PIN_SEL       = 6;
  localparam int PIN_REF       = 7;

  // ****************************************************************
  // reset values of registered outputs
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ****************************************************************
  // peripheral controls feeding the override logic
  // ****************************************************************
  typedef struct packed {
    logic spi_enable;      // spi on
    logic spi_master;      // 1 master, 0 slave
    logic spi_sck_out;     // master clock out
    logic spi_mosi_out;    // master data out
    logic spi_miso_out;    // slave data out
    logic three_wire_mode; // three-wire serial mode
    logic three_wire_dout; // serial data out
    logic timer0_oc_en;    // compare output a connected
    logic timer0_oc_val;   // compare output a level
    logic uart_tx_enable;  // uart transmitter on
    logic uart_tx_data;    // uart tx level
    logic lin_enable;      // lin controller on
    logic lin_tx_data;     // lin tx level
    logic ref_out_enable;  // reference output enable bit
    logic adc_internal_ref;// adc uses an internal reference
    logic adc_external_ref;// pin is external ref or bypass node
    logic pullup_disable;  // global or port-wise pull-up disable
  } paof_periph_s;

  // per-pin override bundle
  typedef struct packed {
    logic puoe;
    logic puov;
    logic ddoe;
    logic direction_override_value;
    logic pvoe;
    logic pvov;
  } paof_ovr_s;

endpackage

// File: rtl/paof_pin.sv
`timescale 1ns/1ps
module paof_pin
  import paof_pkg::*;
(
  input  wire logic      dir_bit,   // data direction bit
  input  wire logic      port_bit,  // port output bit
  input  wire logic      pud,       // pull-up disable
  input  paof_pkg::paof_ovr_s ovr,  // override bundle
  output logic           oe,        // output driver enable
  output logic           val,       // output value
  output logic           pull       // pull-up enable
);

  always_comb begin
    oe   = ovr.ddoe ? ovr.direction_override_value : dir_bit;
    val  = ovr.pvoe ? ovr.pvov : port_bit;
    pull = ovr.puoe ? ovr.puov : (~oe & port_bit & ~pud);
  end

endmodule // paof_pin

// File: verif/paof_sva.sv
`timescale 1ns/1ps
// ****
// pin override checks
// ****
module paof_sva
  import paof_pkg::*;
(
  input wire logic              CLOCK,      // clock
  input wire logic              RST,        // reset
  input wire logic [7:0]        DIR_BITS,   // direction
  input wire logic [7:0]        PORT_BITS,  // port bits
  input paof_pkg::paof_periph_s PERIPH,     // controls
  input wire logic [7:0]        PAD_IN,     // pads
  input wire logic [7:0]        PAD_OE,     // drive
  input wire logic [7:0]        PAD_OUT,    // value
  input wire logic [7:0]        PAD_PULLUP, // pull
  input wire logic [7:0]        PIN_CHANGE_SRC, // change
  input wire logic              SPI_SLAVE_ACTIVE, // selected
  input wire logic              REFERENCE_VOLTAGE_OUTPUT, // ref
  input wire logic [7:0]        PAD_IN_Q    // sampled
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire slv = PERIPH.spi_enable & ~PERIPH.spi_master;
  wire mst = PERIPH.spi_enable & PERIPH.spi_master;
  wire pu  = ~PERIPH.pullup_disable;
  sequence two_run;
    !RST ##1 !RST;
  endsequence
  sel_input_a: assert property (slv |-> !PAD_OE[6] &&
    PAD_PULLUP[6] == (PORT_BITS[6] & pu))
    else $error("select pad driven");
  slave_act_a: assert property (SPI_SLAVE_ACTIVE == (slv && !PAD_IN[6]))
    else $error("slave active wrong");
  sel_master_a: assert property (mst |-> PAD_OE[6] == DIR_BITS[6])
    else $error("select dir wrong");
  clk_data_a: assert property (slv |-> PAD_OE[5:4] == 2'h0)
    else $error("clock or data driven");
  miso_in_a: assert property (mst |-> !PAD_OE[2] &&
    PAD_PULLUP[2] == (PORT_BITS[2] & pu))
    else $error("miso pad wrong");
  serial_out_a: assert property (PERIPH.three_wire_mode && !slv |->
    PAD_OUT[2] == (PERIPH.three_wire_dout & PAD_OE[2]))
    else $error("serial data pad wrong");
  miso_pull_a: assert property (!mst && !PAD_OE[2] |->
    PAD_PULLUP[2] == (PORT_BITS[2] & pu))
    else $error("bit2 pull-up wrong");
  tx_drive_a: assert property (PERIPH.uart_tx_enable || PERIPH.lin_enable |-> PAD_OE[1])
    else $error("tx pad not driven");
  ref_off_a: assert property ((PERIPH.ref_out_enable && PERIPH.adc_internal_ref) ||
    PERIPH.adc_external_ref |-> !PAD_OE[7] && !PAD_PULLUP[7])
    else $error("ref pad active");
  pin_src_a: assert property (PIN_CHANGE_SRC == PAD_IN)
    else $error("change source wrong");
  pad_reg_a: assert property (two_run |-> PAD_IN_Q == $past(PAD_IN))
    else $error("pad sample wrong");
endmodule // paof_sva
bind paof_top paof_sva u_paof_sva (.CLOCK(CLOCK), .RST(RST), .DIR_BITS(DIR_BITS),
  .PORT_BITS(PORT_BITS), .PERIPH(PERIPH), .PAD_IN(PAD_IN), .PAD_OE(PAD_OE),
  .PAD_OUT(PAD_OUT), .PAD_PULLUP(PAD_PULLUP), .PIN_CHANGE_SRC(PIN_CHANGE_SRC),
  .SPI_SLAVE_ACTIVE(SPI_SLAVE_ACTIVE), .REFERENCE_VOLTAGE_OUTPUT(REFERENCE_VOLTAGE_OUTPUT),
  .PAD_IN_Q(PAD_IN_Q));

// File: verif/paof_pads.sv
`timescale 1ns/1ps
// ****
// board pads
// ****
module paof_pads (
  input  wire logic       clk,     // clock
  input  wire logic [7:0] oe,      // device drive
  input  wire logic [7:0] out,     // device value
  input  wire logic [7:0] pull,    // pull-up on
  input  wire logic [7:0] ext_en,  // board drive
  input  wire logic [7:0] ext_val, // board value
  output logic      [7:0] pad      // pad level
);
  logic [7:0] last_q = 8'h00;
  // an undriven pad without pull-up flips each cycle, never a steady guess
  always_ff @(posedge clk) last_q <= pad;
  assign pad = (oe & out) | (~oe & ext_en & ext_val)
             | (~oe & ~ext_en & (pull | ~last_q));
endmodule // paof_pads

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import paof_pkg::*;
  logic         CLOCK = 1'b0;
  logic         RST = 1'b1;
  logic [7:0]   dir = 8'h00, port = 8'h00, x_en = 8'h00, x_val = 8'h00;
  logic [7:0]   pad, oe, out, pull, src, pad_q, prev;
  logic         slave, ref_o, rst_prev = 1'b1;
  logic [31:0]  h;
  logic [23:0]  w;
  paof_periph_s per = '0, p;
  int           error_cnt = 0, checked = 0;
  always #2.5 CLOCK = ~CLOCK;
  paof_top u_paof_top (.CLOCK(CLOCK), .RST(RST), .DIR_BITS(dir), .PORT_BITS(port),
    .PERIPH(per), .PAD_IN(pad), .PAD_OE(oe), .PAD_OUT(out), .PAD_PULLUP(pull),
    .PIN_CHANGE_SRC(src), .SPI_SLAVE_ACTIVE(slave), .REFERENCE_VOLTAGE_OUTPUT(ref_o),
    .PAD_IN_Q(pad_q));
  paof_pads u_paof_pads (.clk(CLOCK), .oe(oe), .out(out), .pull(pull), .ext_en(x_en),
    .ext_val(x_val), .pad(pad));
  function automatic logic [23:0] want(input logic [7:0] d, q, input paof_periph_s c);
    logic [7:0] e, v, u;
    e = d;
    v = q;
    if (c.spi_enable & ~c.spi_master) e[6:4] = 3'h0;
    if (c.spi_enable & c.spi_master) begin
      e[2] = 1'b0;
      v[5:4] = {c.spi_sck_out, c.spi_mosi_out};
    end
    v[2] = (c.spi_enable & ~c.spi_master) ? c.spi_miso_out
         : c.three_wire_mode ? c.three_wire_dout
         : c.timer0_oc_en ? c.timer0_oc_val : q[2];
    u = ~e & q & {8{~c.pullup_disable}};
    if (c.uart_tx_enable | c.lin_enable) begin
      {e[1], u[1]} = 2'h2;
      v[1] = c.lin_enable ? c.lin_tx_data : c.uart_tx_data;
    end
    if ((c.ref_out_enable & c.adc_internal_ref) | c.adc_external_ref) {e[7], u[7]} = 2'h0;
    return {e, v & e, u};
  endfunction
  task chk(input string n, input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", n, exp, seen);
      error_cnt++;
    end
  endtask
  task print_verdict;
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    for (int i = 0; i < 600; i++) begin
      @(posedge CLOCK);
      h = i * 32'h9e37_79b9;
      h = h ^ (h >> 15);
      p = paof_periph_s'(h[16:0]);
      RST <= (i == 300);
      per <= p;
      port <= h[23:16];
      x_en <= h[15:8] ^ h[31:24];
      x_val <= h[7:0] ^ h[23:16];
      // software keeps timer pad an output and serial input pad an input
      dir <= (h[31:24] | {5'h00, p.timer0_oc_en, 2'h0})
           & ~{3'h0, p.three_wire_mode, 4'h0};
      @(negedge CLOCK);
      w = want(dir, port, per);
      chk("pad_oe", 24'(oe), 24'(w[23:16]));
      chk("pad_out", 24'(out), 24'(w[15:8]));
      chk("pad_pull", 24'(pull), 24'(w[7:0]));
      chk("slave", 24'(slave), 24'(per.spi_enable & ~per.spi_master & ~pad[6]));
      chk("ref", 24'(ref_o), 24'(per.ref_out_enable & per.adc_internal_ref));
      chk("src", 24'(src), 24'(pad));
      chk("pad_q", 24'(pad_q), rst_prev ? 24'h00_0000 : 24'(prev));
      prev = pad;
      rst_prev = RST;
    end
    print_verdict;
  end
endmodule // tb
